/* pkg/swrt_pkg.sv */
// Package with constants and carrier types for the single-wire read-byte and triplet engine.
package swrt_pkg;

  // Command codes.
  localparam logic [7:0] SWRT_CMD_READ_BYTE = 8'h96;
  localparam logic [7:0] SWRT_CMD_TRIPLET = 8'h78;

  // Direction bit position in the direction byte.
  localparam int SWRT_DIR_BIT = 7;

  // Clock rate and activity start bound.
  localparam int SWRT_CLK_PS = 5000;
  localparam int SWRT_START_MAX_PS = 262500;
  localparam int SWRT_START_MAX_CYC = (SWRT_START_MAX_PS / SWRT_CLK_PS < 1) ? 1 : SWRT_START_MAX_PS / SWRT_CLK_PS;

  // Slot timing at standard speed, in nanoseconds.
  localparam int SWRT_SLOT_STD_NS = 70000;
  localparam int SWRT_LOW_STD_NS = 6000;
  localparam int SWRT_LOW0_STD_NS = 60000;
  localparam int SWRT_MSR_STD_NS = 15000;
  // Slot timing at overdrive speed, in nanoseconds.
  localparam int SWRT_SLOT_OD_NS = 10000;
  localparam int SWRT_LOW_OD_NS = 1000;
  localparam int SWRT_LOW0_OD_NS = 7500;
  localparam int SWRT_MSR_OD_NS = 2000;

  // Cycle counts derived from the times above at 5 ns per cycle.
  localparam logic [15:0] SWRT_SLOT_STD_CYC = 16'(SWRT_SLOT_STD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_LOW_STD_CYC = 16'(SWRT_LOW_STD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_LOW0_STD_CYC = 16'(SWRT_LOW0_STD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_MSR_STD_CYC = 16'(SWRT_MSR_STD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_SLOT_OD_CYC = 16'(SWRT_SLOT_OD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_LOW_OD_CYC = 16'(SWRT_LOW_OD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_LOW0_OD_CYC = 16'(SWRT_LOW0_OD_NS * 1000 / SWRT_CLK_PS);
  localparam logic [15:0] SWRT_MSR_OD_CYC = 16'(SWRT_MSR_OD_NS * 1000 / SWRT_CLK_PS);

  // Register map of the command port.
  localparam logic [2:0] SWRT_REG_CTRL = 3'h0;
  localparam logic [2:0] SWRT_REG_STATUS = 3'h1;
  localparam logic [2:0] SWRT_REG_DATA = 3'h2;
  localparam logic [2:0] SWRT_REG_IRQ_STAT = 3'h3;
  localparam logic [2:0] SWRT_REG_IRQ_MASK = 3'h4;
  localparam logic [2:0] SWRT_REG_PTR = 3'h5;

  // Field positions of the control register.
  localparam int SWRT_CTRL_OD = 0;
  localparam int SWRT_CTRL_APU = 1;
  // Field positions of the status register.
  localparam int SWRT_ST_BUSY = 0;
  localparam int SWRT_ST_SBR = 5;
  localparam int SWRT_ST_TSB = 6;
  localparam int SWRT_ST_DIR = 7;
  // Interrupt event bits.
  localparam int SWRT_IRQ_DONE = 0;
  localparam int SWRT_IRQ_REFUSED = 1;
  localparam int SWRT_IRQ_ERR = 2;

  // Read pointer values.
  localparam logic [7:0] SWRT_PTR_STATUS = 8'hF0;
  localparam logic [7:0] SWRT_PTR_DATA = 8'hE1;

  // Reset values.
  localparam logic [7:0] SWRT_RST_BYTE = 8'h00;
  localparam logic [15:0] SWRT_RST_CNT = 16'h0000;

  // Sequencer states.
  typedef enum logic [2:0] {
    SWRT_IDLE,
    SWRT_LOW,
    SWRT_REL,
    SWRT_RECOVER
  } swrt_state_e;

  // Command port request carrier.
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } swrt_bus_req_s;

  // Host command strobe carrier.
  typedef struct packed {
    logic code_valid;
    logic [7:0] code;
    logic dir_valid;
    logic [7:0] dir_byte;
  } swrt_cmd_s;

  // All state of the engine.
  typedef struct packed {
    swrt_state_e state;
    logic [15:0] cnt;
    logic [3:0] slot_idx;
    logic is_triplet;
    logic trip_wait_dir;
    logic dir_bit;
    logic cur_val;
    logic first_bit;
    logic [7:0] data_reg;
    logic busy_reg;
    logic sbr_reg;
    logic tsb_reg;
    logic dir_reg;
    logic od_reg;
    logic apu_reg;
    logic [7:0] ptr_reg;
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [7:0] rdata_reg;
    logic line_low_reg;
    logic pullup_reg;
    logic [7:0] start_cnt;
  } swrt_state_s;

endpackage : swrt_pkg

/* verilog/swrt_engine.sv */
// Single-wire read-byte and triplet command engine with command port and interrupt.
//
// Function
// - Read-byte code 96h, no parameter, produces eight read slots.
// - Eight sampled read-byte bits are stored in the read-data register.
// - Each read-byte slot uses the write-one waveform.
// - Read-byte code arriving while busy is not acknowledged and dropped.
// - Read-byte line activity starts within 262.5ns, ends within eight slots.
// - Read pointer returns to status; host selects data register before reading.
// - Busy flag stays high for the eight read-byte slots, then clears.
// - Triplet code 78h plus direction byte gives two reads, then a write.
// - Reads 0,0 make the write slot follow the direction bit.
// - Reads 0,1 force a write-zero slot.
// - Reads 1,0 or 1,1 force a write-one slot.
// - Triplet code arriving while busy: no acknowledge of code or direction byte.
// - Triplet activity starts within 262.5ns, ends within three slots.
// - Busy flag stays high for the three triplet slots.
// - First-bit result updates at first sample; second-bit and direction at second.
// - Direction comes from bit 7; the other seven bits are ignored.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module swrt_engine
  import swrt_pkg::*;
(
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic srst,
  input wire logic clk_en,
  // Host command strobes from the serial host front end.
  input wire swrt_cmd_s cmd,
  output logic code_ack,
  output logic dir_ack,
  // Register command port.
  input wire swrt_bus_req_s bus,
  output logic [7:0] bus_rdata,
  // Single-wire line as an open-drain pin.
  input wire logic line_in,
  output logic line_out,
  output logic line_oe,
  output logic active_pullup,
  // Status and interrupt.
  output logic line_busy_flag,
  output logic irq
);

  swrt_state_s st_reg;
  swrt_state_s st_next;

  // Current speed timing selected by the control register.
  logic [15:0] t_slot;
  logic [15:0] t_low1;
  logic [15:0] t_low0;
  logic [15:0] t_msr;
  logic [15:0] t_low;
  logic code_rb;
  logic code_tr;
  logic accept_rb;
  logic accept_tr;
  logic sample_now;
  logic slot_end;
  logic [2:0] irq_set;

  // Speed selection and slot event decoding.
  always_comb begin
    t_slot = st_reg.od_reg ? SWRT_SLOT_OD_CYC : SWRT_SLOT_STD_CYC;
    t_low1 = st_reg.od_reg ? SWRT_LOW_OD_CYC : SWRT_LOW_STD_CYC;
    t_low0 = st_reg.od_reg ? SWRT_LOW0_OD_CYC : SWRT_LOW0_STD_CYC;
    t_msr = st_reg.od_reg ? SWRT_MSR_OD_CYC : SWRT_MSR_STD_CYC;
    t_low = st_reg.cur_val ? t_low1 : t_low0;
    code_rb = cmd.code_valid && (cmd.code == SWRT_CMD_READ_BYTE);
    code_tr = cmd.code_valid && (cmd.code == SWRT_CMD_TRIPLET);
    accept_rb = code_rb && !st_reg.busy_reg;
    accept_tr = code_tr && !st_reg.busy_reg;
    sample_now = (st_reg.state == SWRT_REL) && (st_reg.cnt == t_msr);
    slot_end = (st_reg.cnt == t_slot - 16'h0001) && (st_reg.state != SWRT_IDLE);
  end

  // Acknowledge strobes toward the host front end.
  assign code_ack = accept_rb || accept_tr;
  assign dir_ack = cmd.dir_valid && st_reg.trip_wait_dir;

  // Next-state logic for the whole engine.
  always_comb begin
    st_next = st_reg;
    irq_set = 3'h0;
    st_next.start_cnt = (st_reg.state == SWRT_IDLE) ? SWRT_RST_BYTE : st_reg.start_cnt;
    // Command port writes.
    if (bus.wr) begin
      case (bus.addr)
        SWRT_REG_CTRL: begin
          st_next.od_reg = bus.wdata[SWRT_CTRL_OD];
          st_next.apu_reg = bus.wdata[SWRT_CTRL_APU];
        end
        SWRT_REG_PTR: begin
          st_next.ptr_reg = bus.wdata;
        end
        SWRT_REG_IRQ_MASK: begin
          st_next.irq_mask_reg = bus.wdata[2:0];
        end
        SWRT_REG_IRQ_STAT: begin
          st_next.irq_stat_reg = st_reg.irq_stat_reg & ~bus.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    // Command port reads, answered one cycle later.
    st_next.rdata_reg = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        SWRT_REG_CTRL: st_next.rdata_reg = {6'h00, st_reg.apu_reg, st_reg.od_reg};
        SWRT_REG_STATUS: st_next.rdata_reg = {st_reg.dir_reg, st_reg.tsb_reg, st_reg.sbr_reg, 4'h0, st_reg.busy_reg};
        SWRT_REG_DATA: begin
          if (st_reg.ptr_reg == SWRT_PTR_DATA) begin
            st_next.rdata_reg = st_reg.data_reg;
          end else begin
            st_next.rdata_reg = {st_reg.dir_reg, st_reg.tsb_reg, st_reg.sbr_reg, 4'h0, st_reg.busy_reg};
          end
        end
        SWRT_REG_IRQ_STAT: st_next.rdata_reg = {5'h00, st_reg.irq_stat_reg};
        SWRT_REG_IRQ_MASK: st_next.rdata_reg = {5'h00, st_reg.irq_mask_reg};
        SWRT_REG_PTR: st_next.rdata_reg = st_reg.ptr_reg;
        default: st_next.rdata_reg = 8'h00;
      endcase
    end
    // A refused code is reported as an event.
    if ((code_rb || code_tr) && st_reg.busy_reg) begin
      irq_set[SWRT_IRQ_REFUSED] = 1'b1;
    end
    // Slot sequencer.
    case (st_reg.state)
      SWRT_IDLE: begin
        st_next.cnt = SWRT_RST_CNT;
        if (accept_rb) begin
          st_next.state = SWRT_LOW;
          st_next.is_triplet = 1'b0;
          st_next.slot_idx = 4'h0;
          st_next.cur_val = 1'b1;
          st_next.busy_reg = 1'b1;
          st_next.ptr_reg = SWRT_PTR_STATUS;
          st_next.line_low_reg = 1'b1;
        end else if (accept_tr) begin
          st_next.trip_wait_dir = 1'b1;
          st_next.busy_reg = 1'b1;
          st_next.ptr_reg = SWRT_PTR_STATUS;
        end
        if (st_reg.trip_wait_dir && cmd.dir_valid) begin
          st_next.trip_wait_dir = 1'b0;
          st_next.dir_bit = cmd.dir_byte[SWRT_DIR_BIT];
          st_next.state = SWRT_LOW;
          st_next.is_triplet = 1'b1;
          st_next.slot_idx = 4'h0;
          st_next.cur_val = 1'b1;
          st_next.line_low_reg = 1'b1;
        end
      end
      SWRT_LOW: begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cnt + 16'h0001 >= t_low) begin
          st_next.state = SWRT_REL;
          st_next.line_low_reg = 1'b0;
        end
      end
      SWRT_REL, SWRT_RECOVER: begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (sample_now && !(st_reg.is_triplet && st_reg.slot_idx == 4'h2)) begin
          if (!st_reg.is_triplet) begin
            st_next.data_reg = {line_in, st_reg.data_reg[7:1]};
          end else if (st_reg.slot_idx == 4'h0) begin
            st_next.sbr_reg = line_in;
            st_next.first_bit = line_in;
          end else begin
            st_next.tsb_reg = line_in;
            if (!st_reg.first_bit && !line_in) begin
              st_next.dir_reg = st_reg.dir_bit;
            end else if (!st_reg.first_bit && line_in) begin
              st_next.dir_reg = 1'b0;
            end else begin
              st_next.dir_reg = 1'b1;
            end
            if (st_reg.first_bit && line_in) begin
              irq_set[SWRT_IRQ_ERR] = 1'b1;
            end
          end
        end
        if (slot_end) begin
          st_next.cnt = SWRT_RST_CNT;
          if ((st_reg.is_triplet && st_reg.slot_idx == 4'h2) || (!st_reg.is_triplet && st_reg.slot_idx == 4'h7)) begin
            st_next.state = SWRT_IDLE;
            st_next.busy_reg = 1'b0;
            irq_set[SWRT_IRQ_DONE] = 1'b1;
          end else begin
            st_next.state = SWRT_LOW;
            st_next.slot_idx = st_reg.slot_idx + 4'h1;
            st_next.line_low_reg = 1'b1;
            if (st_reg.is_triplet && st_reg.slot_idx == 4'h1) begin
              st_next.cur_val = st_next.dir_reg;
            end else begin
              st_next.cur_val = 1'b1;
            end
          end
        end
      end
      default: begin
        st_next.state = SWRT_IDLE;
      end
    endcase
    // Active pullup is driven during the release phase when selected.
    st_next.pullup_reg = st_reg.apu_reg && (st_next.state == SWRT_REL);
    // Sticky events: a set in the same cycle as a clear wins.
    st_next.irq_stat_reg = st_next.irq_stat_reg | irq_set;
  end

  // State register with synchronous reset and clock enable.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.state <= SWRT_IDLE;
      st_reg.ptr_reg <= SWRT_PTR_STATUS;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  // Outputs from registers.
  assign bus_rdata = st_reg.rdata_reg;
  assign line_out = 1'b0;
  assign line_oe = st_reg.line_low_reg;
  assign active_pullup = st_reg.pullup_reg;
  assign line_busy_flag = st_reg.busy_reg;
  assign irq = |(st_reg.irq_stat_reg & st_reg.irq_mask_reg);

  // Busy must be high whenever the line is pulled low.
  a_busy_covers_line: assert property (@(posedge clk) disable iff (srst)
    line_oe |-> line_busy_flag)
    else $error("Line driven while busy flag is low.");

  // An accepted read-byte pulls the line low on the next cycle.
  a_rb_start_fast: assert property (@(posedge clk) disable iff (srst)
    (clk_en && accept_rb) |=> line_oe)
    else $error("Read-byte activity did not start in time.");

  // A code arriving while busy is never acknowledged.
  a_busy_no_ack: assert property (@(posedge clk) disable iff (srst)
    (cmd.code_valid && line_busy_flag) |-> !code_ack)
    else $error("Command acknowledged while busy.");

  // Busy stays set for at least eight cycles after a read-byte accept.
  a_busy_held: assert property (@(posedge clk) disable iff (srst)
    (clk_en && accept_rb) |=> line_busy_flag [*8])
    else $error("Busy flag dropped early.");

  // Triplet with busy high must not acknowledge a direction byte without a pending code.
  a_dir_ack_pending: assert property (@(posedge clk) disable iff (srst)
    dir_ack |-> $past(line_busy_flag))
    else $error("Direction byte acknowledged without pending triplet.");

  // Read-byte slots always use the short low time.
  a_rb_write_one: assert property (@(posedge clk) disable iff (srst)
    (st_reg.state == SWRT_LOW && !st_reg.is_triplet) |-> st_reg.cur_val)
    else $error("Read-byte slot used write-zero waveform.");

  // Reads 0 then 1 give a write-zero direction.
  a_trip_01_zero: assert property (@(posedge clk) disable iff (srst)
    (clk_en && sample_now && st_reg.is_triplet && st_reg.slot_idx == 4'h1 && !st_reg.first_bit && line_in)
    |=> !st_reg.dir_reg)
    else $error("Triplet 0,1 did not choose zero.");

  // Reads with first bit 1 give a write-one direction.
  a_trip_1x_one: assert property (@(posedge clk) disable iff (srst)
    (clk_en && sample_now && st_reg.is_triplet && st_reg.slot_idx == 4'h1 && st_reg.first_bit)
    |=> st_reg.dir_reg)
    else $error("Triplet 1,x did not choose one.");

  // Reads 0 then 0 make the direction follow the requested bit.
  a_trip_00_dir: assert property (@(posedge clk) disable iff (srst)
    (clk_en && sample_now && st_reg.is_triplet && st_reg.slot_idx == 4'h1 && !st_reg.first_bit && !line_in)
    |=> st_reg.dir_reg == $past(st_reg.dir_bit))
    else $error("Triplet 0,0 did not follow the direction bit.");

  // First sample updates the single-bit result.
  a_sbr_update: assert property (@(posedge clk) disable iff (srst)
    (clk_en && sample_now && st_reg.is_triplet && st_reg.slot_idx == 4'h0)
    |=> st_reg.sbr_reg == $past(line_in))
    else $error("Single-bit result not updated at first sample.");

endmodule : swrt_engine

`default_nettype wire

/* testbench/swrt_slave_model.sv */
// Behavioural single-wire slave that answers read slots and reports each slot's waveform.
`timescale 1ns/10ps
`default_nettype none

module swrt_slave_model (
  // Clock.
  input wire logic clk,
  // Line drive of the master and of this slave.
  input wire logic line_oe,
  output logic slave_pull,
  // Observed slot kind, one means a short low pulse.
  output logic obs_valid,
  output logic obs_kind
);
  logic bits_q[$];
  int low_cnt = 0;
  int pull_cnt = 0;
  logic oe_d = 1'b0;

  // Queues the answer of the next read slot.
  task automatic push(input logic b);
    bits_q.push_back(b);
  endtask : push

  initial begin
    slave_pull = 1'b0;
    obs_valid = 1'b0;
    obs_kind = 1'b0;
  end

  // A zero answer holds the line low past the sample point; the pull-up restores it afterwards.
  always @(posedge clk) begin
    oe_d <= line_oe;
    obs_valid <= 1'b0;
    if (line_oe) begin
      low_cnt <= low_cnt + 1;
    end
    if (line_oe && !oe_d) begin
      low_cnt <= 1;
      if (bits_q.size() > 0 && bits_q.pop_front() == 1'b0) begin
        pull_cnt <= 600;
      end
    end
    if (!line_oe && oe_d) begin
      obs_valid <= 1'b1;
      obs_kind <= (low_cnt < 1000); // Long pulses are write-zero slots.
    end
    if (pull_cnt > 0) begin
      pull_cnt <= pull_cnt - 1;
    end
    slave_pull <= (pull_cnt > 1);
  end
endmodule : swrt_slave_model
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the read-byte and triplet engine.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import swrt_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  swrt_cmd_s cmd = '0;
  swrt_bus_req_s bus = '0;
  logic code_ack, dir_ack, line_out, line_oe, active_pullup, line_busy_flag, irq;
  logic [7:0] bus_rdata;
  logic slave_pull, obs_valid, obs_kind, rd_q = 1'b0;
  wire logic line_wire = ~(line_oe | slave_pull);
  logic [7:0] exp_rd[$];
  logic exp_slot[$];
  int mismatches = 0;
  int checked = 0;
  logic [31:0] seed = 32'hB4FFC50A;
  logic [7:0] rbyte;
  int slot_cyc = int'(SWRT_SLOT_OD_CYC);

  swrt_engine swrt_engine_i (.clk(clk), .srst(srst), .clk_en(clk_en), .cmd(cmd), .code_ack(code_ack),
    .dir_ack(dir_ack), .bus(bus), .bus_rdata(bus_rdata), .line_in(line_wire), .line_out(line_out),
    .line_oe(line_oe), .active_pullup(active_pullup), .line_busy_flag(line_busy_flag), .irq(irq));
  swrt_slave_model swrt_slave_model_i (.clk(clk), .line_oe(line_oe), .slave_pull(slave_pull),
    .obs_valid(obs_valid), .obs_kind(obs_kind));

  // Clock at 200 MHz.
  initial begin
    forever #2.5 clk = ~clk;
  end

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [2:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
  endtask : bus_rd

  // Sends a command code and checks the acknowledge in its own cycle.
  task automatic send(input logic [7:0] c, input logic ack);
    @(posedge clk);
    cmd.code_valid <= 1'b1;
    cmd.code <= c;
    #1 chk({7'h00, code_ack}, {7'h00, ack});
    @(posedge clk);
    cmd.code_valid <= 1'b0;
  endtask : send

  // Counts busy cycles and the delay to the first low pulse of the line.
  task automatic run(input int slots, input int n0);
    int n;
    int first;
    n = n0;
    first = -1;
    do begin
      #1;
      if (line_oe && first < 0) first = n;
      n++;
      @(posedge clk);
    end while (line_busy_flag && n < 20 * slot_cyc);
    chk({7'h00, first >= 0 && first <= SWRT_START_MAX_CYC}, 8'h01);
    chk({7'h00, n >= slots * slot_cyc - 2 && n <= slots * slot_cyc + SWRT_START_MAX_CYC}, 8'h01);
  endtask : run

  // One triplet with slave answers b1 and b2 and direction v.
  task automatic trip(input logic b1, input logic b2, input logic v);
    logic w;
    w = b1 | (~b2 & v);
    swrt_slave_model_i.push(b1);
    swrt_slave_model_i.push(b2);
    exp_slot.push_back(1'b1);
    exp_slot.push_back(1'b1);
    exp_slot.push_back(w);
    send(SWRT_CMD_TRIPLET, 1'b1);
    @(posedge clk);
    cmd.dir_valid <= 1'b1;
    cmd.dir_byte <= {v, 7'(xs())};
    #1 chk({7'h00, dir_ack}, 8'h01);
    @(posedge clk);
    cmd.dir_valid <= 1'b0;
    run(3, 1);
    bus_rd(SWRT_REG_STATUS, {w, b2, b1, 5'h00});
  endtask : trip

  // Compares each read result and each observed slot against the oldest note.
  always @(posedge clk) begin
    rd_q <= bus.rd;
    if (rd_q) chk(bus_rdata, exp_rd.pop_front());
    if (obs_valid) chk({7'h00, obs_kind}, {7'h00, exp_slot.pop_front()});
  end

  // Watchdog well beyond the expected run length of about 46,000 cycles.
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    bus_rd(SWRT_REG_STATUS, 8'h00);
    bus_wr(SWRT_REG_CTRL, 8'h01);
    bus_rd(SWRT_REG_CTRL, 8'h01);
    bus_rd(3'h6, 8'h00);
    // Read-byte with refused codes while busy.
    rbyte = 8'(xs());
    for (int i = 0; i < 8; i++) begin
      swrt_slave_model_i.push(rbyte[i]);
      exp_slot.push_back(1'b1);
    end
    send(SWRT_CMD_READ_BYTE, 1'b1);
    send(SWRT_CMD_READ_BYTE, 1'b0);
    send(SWRT_CMD_TRIPLET, 1'b0);
    // Freeze the engine for three edges; the sequence must simply stretch by that much.
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    clk_en <= 1'b1;
    run(8, 7);
    bus_rd(SWRT_REG_DATA, 8'h00);
    bus_wr(SWRT_REG_PTR, SWRT_PTR_DATA);
    bus_rd(SWRT_REG_DATA, rbyte);
    // Interrupt: raised, masked, cleared.
    bus_rd(SWRT_REG_IRQ_STAT, 8'h03);
    chk({7'h00, irq}, 8'h00);
    bus_wr(SWRT_REG_IRQ_MASK, 8'h07);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    bus_wr(SWRT_REG_IRQ_STAT, 8'h03);
    bus_wr(SWRT_REG_IRQ_MASK, 8'h00);
    bus_rd(SWRT_REG_IRQ_STAT, 8'h00);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    // Every answer pair, both directions where they matter.
    trip(1'b0, 1'b0, 1'b1);
    trip(1'b0, 1'b0, 1'b0);
    trip(1'b0, 1'b1, 1'b1);
    trip(1'b1, 1'b0, 1'b0);
    trip(1'b1, 1'b1, 1'b0);
    repeat (4) @(posedge clk);
    chk(8'(exp_slot.size() + exp_rd.size()), 8'h00);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
